/* verilog/sfic_top.sv */
// Status flags and interrupt control with AHB-Lite register slave
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "sfic_defs.svh"
// Overview of operation
// - Flag bits 3 and 4 are software flags; hardware never changes them.
// - Flag bit 5 and interrupt control bits 7..2 read as zero.
// - Sign flag bit 6 mirrors active accumulator msb on update or switch.
// - Zero flag bit 7 is NOR of active accumulator on update or switch.
// - Interrupt control resets to 00h and is freely read and written.
// - No interrupt reaches the processor while global enable is clear.
// - Acknowledge sets the in-service bit, which blocks further interrupts.
// - Software may clear in-service bit to allow nesting.
// - Return or pop-return instruction clears the in-service bit.
// - Module mask resets to 80h; only its bits 1..0 are software writable.
// - Module 0 request needs global enable, mask bit 0, in-service clear.
// - Mask bit 0 clear suppresses all module 0 sources.
// - Processor flags reset to 80h.
// - Software writes only equal, carry, overflow and spare flags.
// - Mask bit 7 is read-only and reads one.
module sfic_top #(
    parameter int ADDR_W = 12,
    parameter int ACC_W = 16
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic hsel_in,
    input wire logic [ADDR_W-1:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire sfic_pkg::sfic_word_t hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output sfic_pkg::sfic_word_t hrdata_out,
    input wire logic [ACC_W-1:0] acc_value_in,
    input wire logic acc_update_in,
    input wire logic alu_update_in,
    input wire logic alu_carry_in,
    input wire logic alu_equal_in,
    input wire logic alu_overflow_in,
    input wire logic irq_ack_in,
    input wire logic irq_return_op_in,
    input wire logic pop_irq_return_op_in,
    input wire sfic_pkg::sfic_byte_t mod_req_in,
    output logic core_irq_req_out,
    output sfic_pkg::sfic_byte_t flags_out,
    output logic irq_out
);
    import sfic_pkg::*;

    // =====================================================
    // Declarations
    sfic_bus_state_t bus_state_reg;
    sfic_word_t hrdata_reg;
    logic [7:0] idx_reg;
    logic hreadyout_reg, hresp_reg, write_reg, take, busy;
    logic sel_flags, sel_ic, sel_mask, sel_stat, sel_emask;
    logic wr_flags, wr_ic, wr_mask, wr_emask, rd_stat;
    logic global_irq_on_reg, irq_active_bit_reg, mod0_mask_reg, mod1_mask_reg, special_mask;
    sfic_byte_t rdata8, module_mask_reg, irq_ctrl_reg;
    sfic_byte_t evt_stat_reg, evt_stat_next, evt_mask_reg, evt_set;
    logic any_ret, masked_req, core_irq_req_reg, irq_out_reg;

    sfic_flags_if #(.ACC_W(ACC_W)) fif ();

    // =====================================================
    // Bus phase tracking: one wait cycle per transfer
    assign take = hsel_in && htrans_in[1] && hready_in;
    assign busy = (bus_state_reg == BUS_DATA);

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            bus_state_reg <= BUS_IDLE;
            hreadyout_reg <= 1'b1;
        end else begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (take) begin
                        bus_state_reg <= BUS_DATA;
                        hreadyout_reg <= 1'b0;
                    end
                end
                BUS_DATA: begin
                    bus_state_reg <= BUS_IDLE;
                    hreadyout_reg <= 1'b1;
                end
                default: begin
                    bus_state_reg <= BUS_IDLE;
                    hreadyout_reg <= 1'b1;
                end
            endcase
        end
    end

    // Address phase capture; misaligned bytes fall outside the map
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            idx_reg <= 8'hFF;
            write_reg <= 1'b0;
        end else if (take) begin
            idx_reg <= (haddr_in[1:0] == 2'h0 && haddr_in[ADDR_W-1:10] == '0)
                       ? haddr_in[9:2] : 8'hFF;
            write_reg <= hwrite_in;
        end
    end

    // =====================================================
    // Decode
    always_comb begin
        sel_flags = 1'b0;
        sel_ic = 1'b0;
        sel_mask = 1'b0;
        sel_stat = 1'b0;
        sel_emask = 1'b0;
        if (idx_reg == `SFIC_IDX_FLAGS) begin
            sel_flags = 1'b1;
        end else if (idx_reg == `SFIC_IDX_IRQ_CTRL) begin
            sel_ic = 1'b1;
        end else if (idx_reg == `SFIC_IDX_MOD_MASK) begin
            sel_mask = 1'b1;
        end else if (idx_reg == `SFIC_IDX_EVT_STAT) begin
            sel_stat = 1'b1;
        end else if (idx_reg == `SFIC_IDX_EVT_MASK) begin
            sel_emask = 1'b1;
        end
    end

    assign wr_flags = busy && write_reg && sel_flags;
    assign wr_ic = busy && write_reg && sel_ic;
    assign wr_mask = busy && write_reg && sel_mask;
    assign wr_emask = busy && write_reg && sel_emask;
    assign rd_stat = busy && !write_reg && sel_stat;

    assign irq_ctrl_reg = {6'h00, irq_active_bit_reg, global_irq_on_reg};
    assign special_mask = 1'b1;
    assign module_mask_reg = {special_mask, 5'h00, mod1_mask_reg, mod0_mask_reg};

    always_comb begin
        rdata8 = 8'h00;
        if (sel_flags) begin
            rdata8 = fif.flags;
        end else if (sel_ic) begin
            rdata8 = irq_ctrl_reg;
        end else if (sel_mask) begin
            rdata8 = module_mask_reg;
        end else if (sel_stat) begin
            rdata8 = evt_stat_reg;
        end else if (sel_emask) begin
            rdata8 = evt_mask_reg;
        end
    end

    // Read data registered at end of wait cycle
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            hrdata_reg <= 32'h00000000;
            hresp_reg <= 1'b0;
        end else begin
            hresp_reg <= 1'b0;
            if (busy && !write_reg) begin
                hrdata_reg <= {24'h000000, rdata8};
            end
        end
    end

    // =====================================================
    // Flags register link
    assign fif.sw_we = wr_flags;
    assign fif.sw_wdata = hwdata_in[7:0];
    assign fif.acc_upd = acc_update_in;
    assign fif.acc = acc_value_in;
    assign fif.alu_upd = alu_update_in;
    assign fif.alu_carry = alu_carry_in;
    assign fif.alu_equal = alu_equal_in;
    assign fif.alu_ovfl = alu_overflow_in;

    sfic_flags u_flags (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .fif(fif)
    );

    // =====================================================
    // Interrupt control
    assign any_ret = irq_return_op_in || pop_irq_return_op_in;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            global_irq_on_reg <= 1'b0;
        end else if (wr_ic) begin
            global_irq_on_reg <= hwdata_in[`SFIC_IC_GLOBAL];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            irq_active_bit_reg <= 1'b0;
        end else if (irq_ack_in) begin
            irq_active_bit_reg <= 1'b1;
        end else if (any_ret) begin
            irq_active_bit_reg <= 1'b0;
        end else if (wr_ic) begin
            irq_active_bit_reg <= hwdata_in[`SFIC_IC_ACTIVE];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            mod0_mask_reg <= 1'b0;
            mod1_mask_reg <= 1'b0;
        end else if (wr_mask) begin
            mod0_mask_reg <= hwdata_in[`SFIC_MASK_MOD0];
            mod1_mask_reg <= hwdata_in[`SFIC_MASK_MOD1];
        end
    end

    // module 0 gated by mask, enable, in-service
    assign masked_req = |(mod_req_in & module_mask_reg);

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            core_irq_req_reg <= 1'b0;
        end else begin
            core_irq_req_reg <= global_irq_on_reg && !irq_active_bit_reg && masked_req;
        end
    end

    // =====================================================
    // Event status, read clears, set wins
    always_comb begin
        evt_set = 8'h00;
        evt_set[`SFIC_EVT_ACK] = irq_ack_in;
        evt_set[`SFIC_EVT_RET] = any_ret;
        evt_set[`SFIC_EVT_HELD] = global_irq_on_reg && irq_active_bit_reg && masked_req;
        evt_stat_next = (rd_stat ? 8'h00 : evt_stat_reg) | evt_set;
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            evt_stat_reg <= `SFIC_EVT_RST;
        end else begin
            evt_stat_reg <= evt_stat_next;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            evt_mask_reg <= `SFIC_EVT_RST;
        end else if (wr_emask) begin
            evt_mask_reg <= hwdata_in[7:0] & `SFIC_EVT_RW_MASK;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            irq_out_reg <= 1'b0;
        end else begin
            irq_out_reg <= |(evt_stat_next & evt_mask_reg);
        end
    end

    // =====================================================
    // Outputs
    assign hreadyout_out = hreadyout_reg;
    assign hresp_out = hresp_reg;
    assign hrdata_out = hrdata_reg;
    assign core_irq_req_out = core_irq_req_reg;
    assign flags_out = fif.flags;
    assign irq_out = irq_out_reg;

    // =====================================================
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    chk_ack_sets_active: assert property (
        irq_ack_in |=> irq_active_bit_reg ##1 !core_irq_req_out)
        else $error("acknowledge did not block requests");
    chk_ret_clears: assert property (
        any_ret && !irq_ack_in |=> !irq_active_bit_reg)
        else $error("return did not clear in-service");
    chk_sw_clear: assert property (
        wr_ic && !hwdata_in[`SFIC_IC_ACTIVE] && !irq_ack_in |=> !irq_active_bit_reg)
        else $error("software clear of in-service failed");
    chk_no_global: assert property (
        !global_irq_on_reg |=> !core_irq_req_out)
        else $error("request without global enable");
    chk_mod0_request: assert property (
        global_irq_on_reg && !irq_active_bit_reg && mod0_mask_reg && mod_req_in[0]
        |=> core_irq_req_out)
        else $error("module 0 request not raised");
    chk_mod0_masked: assert property (
        !mod0_mask_reg && mod_req_in[7:1] == 7'h00 |=> !core_irq_req_out)
        else $error("masked module 0 request leaked");
    chk_req_or: assert property (
        core_irq_req_out |-> $past(global_irq_on_reg && !irq_active_bit_reg && masked_req))
        else $error("request without cause");
    chk_ic_resvd: assert property (
        busy && !write_reg && sel_ic |=> hrdata_out[31:2] == 30'h00000000)
        else $error("control reserved bits not zero");
    chk_special_ro: assert property (
        busy && !write_reg && sel_mask |=> hrdata_out[7:0] ==? 8'b1000_00??)
        else $error("mask bit 7 or reserved bits wrong");
    chk_ic_reset: assert property (
        $fell(reset_in) |-> irq_ctrl_reg == `SFIC_IRQ_CTRL_RST && !core_irq_req_out)
        else $error("control reset value wrong");
    chk_mask_reset: assert property (
        $fell(reset_in) |-> module_mask_reg == `SFIC_MOD_MASK_RST)
        else $error("mask reset value wrong");
    chk_bus_wait: assert property (
        take |=> !hreadyout_out ##1 hreadyout_out)
        else $error("bus answer timing wrong");

    cov_ack: cover property (irq_ack_in ##1 irq_active_bit_reg);
    cov_nesting: cover property (wr_ic && irq_active_bit_reg ##[1:20] irq_ack_in);
    cov_irq_out: cover property (irq_out_reg ##[1:10] rd_stat);
    cov_return: cover property (irq_active_bit_reg ##1 any_ret);
endmodule : sfic_top
`default_nettype wire

/* verilog/sfic_defs.svh */
// Offsets, field positions and reset values of the status flag and interrupt block
`ifndef SFIC_DEFS_SVH
`define SFIC_DEFS_SVH

// Register indices; byte address is four times the index
`define SFIC_IDX_FLAGS 8'h04
`define SFIC_IDX_IRQ_CTRL 8'h05
`define SFIC_IDX_MOD_MASK 8'h06
`define SFIC_IDX_EVT_STAT 8'h10
`define SFIC_IDX_EVT_MASK 8'h11

// Reset values
`define SFIC_FLAGS_RST 8'h80
`define SFIC_IRQ_CTRL_RST 8'h00
`define SFIC_MOD_MASK_RST 8'h80
`define SFIC_EVT_RST 8'h00

// Processor flags fields
`define SFIC_FLG_EQUAL 0
`define SFIC_FLG_CARRY 1
`define SFIC_FLG_OVFL 2
`define SFIC_FLG_SPARE0 3
`define SFIC_FLG_SPARE1 4
`define SFIC_FLG_RSVD 5
`define SFIC_FLG_SIGN 6
`define SFIC_FLG_ZERO 7

// Interrupt control fields
`define SFIC_IC_GLOBAL 0
`define SFIC_IC_ACTIVE 1

// Module mask fields
`define SFIC_MASK_MOD0 0
`define SFIC_MASK_MOD1 1
`define SFIC_MASK_SPECIAL 7

// Event status fields
`define SFIC_EVT_ACK 0
`define SFIC_EVT_RET 1
`define SFIC_EVT_HELD 2
`define SFIC_EVT_RW_MASK 8'h07

`endif

/* verilog/sfic_pkg.sv */
// Types shared by the status flag and interrupt block
package sfic_pkg;
    typedef logic [7:0] sfic_byte_t;
    typedef logic [31:0] sfic_word_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } sfic_bus_state_t;
endpackage : sfic_pkg

/* verilog/sfic_flags_if.sv */
// Link between register slave and processor flags register
`timescale 1ns/10ps
`default_nettype none
interface sfic_flags_if #(parameter int ACC_W = 16);
    logic sw_we;
    logic [7:0] sw_wdata;
    logic acc_upd;
    logic [ACC_W-1:0] acc;
    logic alu_upd;
    logic alu_carry;
    logic alu_equal;
    logic alu_ovfl;
    logic [7:0] flags;
    modport ctrl (output sw_we, sw_wdata, acc_upd, acc, alu_upd, alu_carry,
                  alu_equal, alu_ovfl, input flags);
    modport regs (input sw_we, sw_wdata, acc_upd, acc, alu_upd, alu_carry,
                  alu_equal, alu_ovfl, output flags);
endinterface : sfic_flags_if
`default_nettype wire

/* verilog/sfic_flags.sv */
// Processor flags register: sign, zero, ALU flags and spare flags
`timescale 1ns/10ps
`default_nettype none
`include "sfic_defs.svh"
module sfic_flags (
    input wire logic core_clk_in,
    input wire logic reset_in,
    sfic_flags_if.regs fif
);
    import sfic_pkg::*;

    sfic_byte_t flags_reg;
    sfic_byte_t flags_next;

    // =====================================================
    // Next value
    always_comb begin
        flags_next = flags_reg;
        // spare flags set by software only
        if (fif.sw_we) begin
            flags_next[`SFIC_FLG_SPARE1:0] = fif.sw_wdata[`SFIC_FLG_SPARE1:0];
        end
        // ALU result overrides software on its own bits
        if (fif.alu_upd) begin
            flags_next[`SFIC_FLG_EQUAL] = fif.alu_equal;
            flags_next[`SFIC_FLG_CARRY] = fif.alu_carry;
            flags_next[`SFIC_FLG_OVFL] = fif.alu_ovfl;
        end
        if (fif.acc_upd) begin
            flags_next[`SFIC_FLG_SIGN] = fif.acc[$bits(fif.acc)-1];
            flags_next[`SFIC_FLG_ZERO] = ~|fif.acc;
        end
        flags_next[`SFIC_FLG_RSVD] = 1'b0;
    end

    // =====================================================
    // Register
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            flags_reg <= `SFIC_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign fif.flags = flags_reg;

    // =====================================================
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    chk_sign_follow: assert property (
        fif.acc_upd |=> flags_reg[`SFIC_FLG_SIGN] == $past(fif.acc[$bits(fif.acc)-1]))
        else $error("sign flag does not follow accumulator");
    chk_zero_follow: assert property (
        fif.acc_upd |=> flags_reg[`SFIC_FLG_ZERO] == $past(~|fif.acc))
        else $error("zero flag does not follow accumulator");
    chk_spare_hold: assert property (
        !fif.sw_we |=> $stable(flags_reg[`SFIC_FLG_SPARE1:`SFIC_FLG_SPARE0]))
        else $error("spare flags changed without a write");
    chk_hw_bits_ro: assert property (
        fif.sw_we && !fif.acc_upd |=> $stable(flags_reg[7:6]))
        else $error("software changed sign or zero flag");
    chk_flag_resvd: assert property (
        flags_reg[`SFIC_FLG_RSVD] == 1'b0)
        else $error("reserved flag bit set");
    chk_flags_reset: assert property (
        $fell(reset_in) |-> flags_reg == `SFIC_FLAGS_RST)
        else $error("flags reset value wrong");
endmodule : sfic_flags
`default_nettype wire

/* verification/sfic_core_model.sv */
// Processor core model: acknowledges requests and issues return strobes
`timescale 1ns/10ps
`default_nettype none
module sfic_core_model (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic irq_req_in,
    input wire logic auto_ack_in,
    input wire logic [3:0] ack_delay_in,
    input wire logic ret_cmd_in,
    input wire logic pop_cmd_in,
    output logic irq_ack_out,
    output logic irq_return_op_out,
    output logic pop_irq_return_op_out
);
    logic [3:0] wait_reg;
    logic busy_reg;
    // Acknowledge after a chosen delay, once per request
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            wait_reg <= 4'h0;
            busy_reg <= 1'b0;
            irq_ack_out <= 1'b0;
        end else begin
            irq_ack_out <= 1'b0;
            if (!irq_req_in) begin
                busy_reg <= 1'b0;
                wait_reg <= 4'h0;
            end else if (auto_ack_in && !busy_reg) begin
                if (wait_reg == ack_delay_in) begin
                    irq_ack_out <= 1'b1;
                    busy_reg <= 1'b1;
                end else begin
                    wait_reg <= wait_reg + 4'h1;
                end
            end
        end
    end
    always_ff @(posedge core_clk_in) begin
        irq_return_op_out <= ret_cmd_in & ~reset_in;
        pop_irq_return_op_out <= pop_cmd_in & ~reset_in;
    end
endmodule : sfic_core_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking testbench of the status flag and interrupt block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
    import sfic_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq_req, irq_o, ack, ret, pop;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    sfic_word_t hwdata = 32'h0, hrdata, rd;
    logic [15:0] acc = 16'h0;
    logic acc_upd = 1'b0, alu_upd = 1'b0, alu_c = 1'b0, alu_e = 1'b0, alu_ov = 1'b0;
    logic auto_ack = 1'b0, ret_cmd = 1'b0, pop_cmd = 1'b0;
    logic [3:0] ack_dly = 4'h0;
    sfic_byte_t mod_req = 8'h00, flags, exp_flags;
    int n_fail = 0, n_compared = 0;
    always #10 core_clk_in = ~core_clk_in;
    sfic_top dut_u (.core_clk_in(core_clk_in), .reset_in(reset_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
        .hwdata_in(hwdata), .hready_in(hreadyout), .hreadyout_out(hreadyout),
        .hresp_out(hresp), .hrdata_out(hrdata), .acc_value_in(acc), .acc_update_in(acc_upd),
        .alu_update_in(alu_upd), .alu_carry_in(alu_c), .alu_equal_in(alu_e),
        .alu_overflow_in(alu_ov), .irq_ack_in(ack), .irq_return_op_in(ret),
        .pop_irq_return_op_in(pop), .mod_req_in(mod_req), .core_irq_req_out(irq_req),
        .flags_out(flags), .irq_out(irq_o));
    sfic_core_model core_u (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .irq_req_in(irq_req), .auto_ack_in(auto_ack), .ack_delay_in(ack_dly),
        .ret_cmd_in(ret_cmd), .pop_cmd_in(pop_cmd), .irq_ack_out(ack),
        .irq_return_op_out(ret), .pop_irq_return_op_out(pop));
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // One AHB-Lite single word transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input sfic_word_t wd,
                        output sfic_word_t rdv);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge core_clk_in); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge core_clk_in); while (hreadyout !== 1'b1);
        rdv = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask : xfer
    task automatic wr(input logic [11:0] a, input sfic_byte_t d);
        sfic_word_t dummy;
        xfer(1'b1, a, {24'h0, d}, dummy);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input sfic_byte_t e);
        xfer(1'b0, a, 32'h0, rd);
        `CHK("read data", {24'h0, e}, rd)
    endtask : rd_chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : tick
    task automatic get_ack();
        int i;
        auto_ack <= 1'b1;
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge core_clk_in);
        if (ack !== 1'b1) begin n_fail++; $display("ERROR ack expected 1 seen %b", ack); end
        auto_ack <= 1'b0;
        tick(3);
    endtask : get_ack
    function automatic sfic_byte_t acc_flags(sfic_byte_t f, logic [15:0] v);
        return {~|v, v[15], f[5:0]};
    endfunction : acc_flags
    initial begin
        int k;
        sfic_byte_t d;
        void'($urandom(32'h5BFE));
        tick(8);
        reset_in <= 1'b0;
        tick(1);
        exp_flags = 8'h80;
        rd_chk(12'h010, 8'h80);
        rd_chk(12'h014, 8'h00);
        rd_chk(12'h018, 8'h80);
        rd_chk(12'h020, 8'h00);
        wr(12'h010, 8'hFF);
        exp_flags = 8'h9F;
        rd_chk(12'h010, exp_flags);
        for (k = 0; k < 12; k++) begin
            d = 8'($urandom);
            wr(12'h018, d);
            rd_chk(12'h018, {1'b1, 5'h00, d[1:0]});
            wr(12'h014, d & 8'hFD);
            rd_chk(12'h014, d & 8'h01);
            wr(12'h010, d);
            exp_flags = {exp_flags[7:6], 1'b0, d[4:0]};
            `CHK("flags", exp_flags, flags)
            acc <= (k < 2) ? 16'h0000 : 16'($urandom);
            acc_upd <= 1'b1;
            alu_upd <= k[0];
            {alu_ov, alu_c, alu_e} <= 3'($urandom);
            tick(1);
            exp_flags = acc_flags(exp_flags, acc);
            if (alu_upd) exp_flags[2:0] = {alu_ov, alu_c, alu_e};
            acc_upd <= 1'b0;
            alu_upd <= 1'b0;
            tick(1);
            `CHK("flags acc", exp_flags, flags)
            rd_chk(12'h010, exp_flags);
        end
        wr(12'h014, 8'h00);
        wr(12'h018, 8'h00);
        mod_req <= 8'h80;
        tick(3);
        `CHK("special off", 1'b0, irq_req)
        wr(12'h014, 8'h01);
        tick(3);
        `CHK("special on", 1'b1, irq_req)
        mod_req <= 8'h7D;
        tick(3);
        `CHK("mask0 off", 1'b0, irq_req)
        wr(12'h014, 8'h00);
        wr(12'h018, 8'h01);
        tick(3);
        `CHK("global off", 1'b0, irq_req)
        wr(12'h044, 8'h01);
        wr(12'h014, 8'h01);
        tick(3);
        `CHK("mod0 req", 1'b1, irq_req)
        ack_dly <= 4'h3;
        get_ack();
        `CHK("req in service", 1'b0, irq_req)
        `CHK("irq ack event", 1'b1, irq_o)
        rd_chk(12'h014, 8'h03);
        xfer(1'b0, 12'h040, 32'h0, rd);
        `CHK("ack status", 1'b1, rd[0])
        tick(2);
        `CHK("irq cleared", 1'b0, irq_o)
        wr(12'h014, 8'h01);
        tick(3);
        `CHK("nested req", 1'b1, irq_req)
        for (k = 0; k < 2; k++) begin
            ack_dly <= 4'($urandom_range(0, 5));
            get_ack();
            rd_chk(12'h014, 8'h03);
            ret_cmd <= (k == 0);
            pop_cmd <= (k == 1);
            tick(1);
            ret_cmd <= 1'b0;
            pop_cmd <= 1'b0;
            tick(3);
            rd_chk(12'h014, 8'h01);
            xfer(1'b0, 12'h040, 32'h0, rd);
            `CHK("event status", 3'h7, rd[2:0])
        end
        finish_test();
    end
    initial begin
        #(20 * 20000);
        n_fail++;
        $display("ERROR watchdog expected done seen hang");
        finish_test();
    end
endmodule : tb
`default_nettype wire
